// ### core/sopr_top.sv
// system option registers, eeprom block protect and their decoded controls
//
// The APB register port was decided locally.
`timescale 1ns/1ps
`include "sopr_cfg.svh"

module sopr_top (
  // clock and reset
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  // apb slave
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [11:0]           paddr,
  input  wire logic [31:0]           pwdata,
  output logic      [31:0]           prdata,
  output logic                       pready,
  output logic                       pslverr,
  // operating mode from the mode latch
  input  wire logic                  special_mode,
  input  wire logic                  expanded_mode,
  // cpu and clock events
  input  wire logic                  stop_exit,
  input  wire logic                  instr_begin,
  input  wire logic                  clock_slow_det,
  input  wire logic                  aux_clock_out_en,
  // pins sampled from outside
  input  wire logic                  irq_n,
  input  wire logic                  crystal_input,
  // port C data and direction
  input  wire logic [7:0]            portc_data,
  input  wire logic [7:0]            portc_dir,
  // eeprom request to check
  input  wire sopr_pkg::sopr_ee_req_t ee_req,
  // decoded controls
  output sopr_pkg::sopr_opts_t       opts,
  output logic                       irq_request,
  output logic                       cpu_hold,
  output logic                       clock_fail_reset,
  output logic                       stop_allowed,
  output logic                       ee_denied,
  // pins driven
  output logic                       instr_start_strobe_n_o,
  output logic                       instr_start_strobe_n_oe,
  output logic [7:0]                 portc_o,
  output logic [7:0]                 portc_oe,
  output logic                       aux_clock_pin
);
  import sopr_pkg::*;

  localparam logic [9:0] ADC_LAST = 10'(`SOPR_ADC_CYCLES - 1);

  sopr_state_t s;
  sopr_state_t next_s;

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  logic [9:0] idx;
  logic       mapped;
  logic       wr;
  logic [7:0] wd;
  logic [7:0] rd;
  logic       win_open;
  logic       test_mode;
  logic       prot_ok;
  logic       xt_edge;
  logic [2:0] aux_last;

  assign idx       = paddr[11:2];
  assign wd        = pwdata[7:0];
  assign wr        = psel & penable & pwrite & mapped;
  assign win_open  = s.win_cnt != `SOPR_WIN_CYCLES;
  assign test_mode = special_mode & expanded_mode;
  // protected bits: special modes always, else first write inside window
  assign prot_ok   = special_mode | (win_open & ~s.once_opt1);
  // zero wait state slave; pready never stalls
  assign pready    = 1'b1;
  assign pslverr   = psel & penable & ~mapped;
  assign prdata    = s.prdata;

  // register select and read mux
  always_comb begin
    mapped = 1'b1;
    rd     = 8'h00;
    if (paddr[1:0] != 2'b00) begin
      mapped = 1'b0;
    end else if (idx == `SOPR_IDX_SYSTEM_OPTIONS_2) begin
      rd = s.system_options_2 & `SOPR_SYSTEM_OPTIONS_2_WMASK | (s.system_options_2 & 8'h10);
    end else if (idx == `SOPR_IDX_OPT1) begin
      rd = s.opt1;
    end else if (idx == `SOPR_IDX_EEPROM_BLOCK_PROTECT) begin
      rd = s.eeprom_block_protect;
    end else if (idx == `SOPR_IDX_STAT) begin
      rd = {2'b00, expanded_mode, special_mode, s.aux_settle != 5'd0,
            s.osc == SOPR_WAIT, win_open, s.adc_ready};
    end else begin
      mapped = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // aux divide half period in crystal edges
  // ----------------------------------------------------------------
  // both crystal edges count, so a divide by n toggles every n edges
  always_comb begin
    case (s.aux_div)
      2'b01:   aux_last = 3'd3;
      2'b10:   aux_last = 3'd5;
      2'b11:   aux_last = 3'd7;
      default: aux_last = 3'd0;
    endcase
  end

  // edge seen on the second and third sync stage only
  assign xt_edge = s.xt_s2 ^ s.xt_s3;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    next_s = s;
    // mode dependent reset value caught once after release
    if (!s.started) begin
      next_s.started           = 1'b1;
      next_s.system_options_2[`SOPR_B_IRVBC] = test_mode;
    end
    // time protection window
    if (win_open) begin
      next_s.win_cnt = s.win_cnt + 7'd1;
    end

    // register writes at the access edge
    if (wr && idx == `SOPR_IDX_OPT1) begin
      next_s.opt1 = (s.opt1 & `SOPR_OPT1_PROT) | (wd & ~`SOPR_OPT1_PROT);
      if (prot_ok) begin
        next_s.opt1 = wd;
        next_s.opt1[`SOPR_B_CLOCK_MONITOR_FORCE] = wd[`SOPR_B_CLOCK_MONITOR_FORCE] | s.opt1[`SOPR_B_CLOCK_MONITOR_FORCE];
      end
      if (!special_mode && win_open) begin
        next_s.once_opt1 = 1'b1;
      end
    end else if (wr && idx == `SOPR_IDX_SYSTEM_OPTIONS_2) begin
      next_s.system_options_2 = (wd & `SOPR_SYSTEM_OPTIONS_2_WMASK) | (s.system_options_2 & 8'h10);
      // boot and test modes both count as special here
      if (special_mode || !s.once_irv) begin
        next_s.system_options_2[`SOPR_B_IRVBC] = wd[`SOPR_B_IRVBC];
        next_s.once_irv            = ~special_mode;
      end
    end else if (wr && idx == `SOPR_IDX_EEPROM_BLOCK_PROTECT) begin
      // outside the single chance only more protection is accepted
      if (special_mode) begin
        next_s.eeprom_block_protect = wd;
      end else if (win_open && !s.once_eeprom_block_protect) begin
        next_s.eeprom_block_protect      = wd;
        next_s.once_eeprom_block_protect = 1'b1;
      end else begin
        next_s.eeprom_block_protect = s.eeprom_block_protect | wd;
      end
    end

    // read data captured in the setup phase
    if (psel && !penable && !pwrite) begin
      next_s.prdata = {24'h000000, rd};
    end

    // converter power up settling flag
    if (!s.opt1[`SOPR_B_ANALOG_POWER_UP]) begin
      next_s.adc_cnt   = 10'd0;
      next_s.adc_ready = 1'b0;
    end else if (s.adc_cnt != ADC_LAST) begin
      next_s.adc_cnt = s.adc_cnt + 10'd1;
    end else begin
      next_s.adc_ready = 1'b1;
    end

    // oscillator start-up delay sequencer
    case (s.osc)
      SOPR_RUN: begin
        if (stop_exit) begin
          next_s.osc     = SOPR_WAIT;
          next_s.dly_cnt = s.opt1[`SOPR_B_DLY] ? `SOPR_DLY_LONG - 12'd1
                                               : `SOPR_DLY_SHORT - 12'd1;
        end
      end
      SOPR_WAIT: begin
        if (s.dly_cnt == 12'd0) begin
          next_s.osc = SOPR_RUN;
        end else begin
          next_s.dly_cnt = s.dly_cnt - 12'd1;
        end
      end
      default: next_s.osc = SOPR_RUN;
    endcase

    // irq pin synchroniser
    next_s.irq_s1 = irq_n;
    next_s.irq_s2 = s.irq_s1;
    next_s.irq_s3 = s.irq_s2;

    // instruction strobe: low pulse, then optional high drive
    // the high drive lasts a whole bus cycle, not a quarter
    next_s.lir_lo = instr_begin & expanded_mode;
    next_s.lir_hi = s.lir_lo & s.system_options_2[`SOPR_B_LIRDRV];

    // port C driver, open drain drives only the low level
    if (s.system_options_2[`SOPR_B_CPOD]) begin
      next_s.pc_o  = 8'h00;
      next_s.pc_oe = portc_dir & ~portc_data;
    end else begin
      next_s.pc_o  = portc_data;
      next_s.pc_oe = portc_dir;
    end

    // crystal synchroniser; limits usable crystals to well below pclk
    next_s.xt_s1 = crystal_input;
    next_s.xt_s2 = s.xt_s1;
    next_s.xt_s3 = s.xt_s2;

    // aux divider restarts and settles after a rate change
    next_s.aux_div = s.system_options_2[1:0];
    if (s.aux_div != s.system_options_2[1:0]) begin
      next_s.aux_cnt    = 3'd0;
      next_s.aux_settle = `SOPR_AUX_SETTLE;
    end else begin
      if (s.aux_settle != 5'd0) begin
        next_s.aux_settle = s.aux_settle - 5'd1;
      end
      if (xt_edge) begin
        if (s.aux_cnt == aux_last) begin
          next_s.aux_cnt = 3'd0;
          next_s.aux_clk = ~s.aux_clk;
        end else begin
          next_s.aux_cnt = s.aux_cnt + 3'd1;
        end
      end
    end
    next_s.aux_pin = aux_clock_out_en & (s.aux_div == 2'b00 ? s.xt_s2 : s.aux_clk);
  end

  // state register, constants only under reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s            <= '0;
      s.opt1       <= `SOPR_RST_OPT1;
      s.system_options_2       <= `SOPR_RST_SYSTEM_OPTIONS_2;
      s.eeprom_block_protect      <= `SOPR_RST_EEPROM_BLOCK_PROTECT;
      s.osc        <= SOPR_WAIT;
      s.dly_cnt    <= `SOPR_DLY_LONG - 12'd1;
      // irq sync starts at the idle pin level, so no false request follows reset
      s.irq_s1     <= 1'b1;
      s.irq_s2     <= 1'b1;
      s.irq_s3     <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  // ----------------------------------------------------------------
  // eeprom protection check
  // ----------------------------------------------------------------
  function automatic logic [4:0] sopr_region(input logic [11:0] off);
    logic [4:0] r;
    r = 5'b00000;
    if (off >= `SOPR_BLK4_LO) begin
      r = 5'b10000;
    end else if (off >= `SOPR_BLK3_LO) begin
      r = 5'b01000;
    end else if (off >= `SOPR_BLK2_LO) begin
      r = 5'b00100;
    end else if (off >= `SOPR_BLK1_LO) begin
      r = 5'b00010;
    end else if (off >= `SOPR_BLK0_LO) begin
      r = 5'b00001;
    end
    return r;
  endfunction : sopr_region

  // region, erase and config protection combined
  always_comb begin
    ee_denied = 1'b0;
    if ((ee_req.prog | ee_req.row_erase) &&
        (sopr_region(ee_req.offset) & s.eeprom_block_protect[4:0]) != 5'b00000) begin
      ee_denied = 1'b1;
    end
    if ((ee_req.bulk_erase | ee_req.row_erase) && s.eeprom_block_protect[`SOPR_B_BULK_ERASE_PROTECT]) begin
      ee_denied = 1'b1;
    end
    if (ee_req.cfg_write && s.eeprom_block_protect[`SOPR_B_PTCFG] && !special_mode) begin
      ee_denied = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // decoded outputs
  // ----------------------------------------------------------------
  assign opts.analog_power_up          = s.opt1[`SOPR_B_ANALOG_POWER_UP];
  assign opts.charge_pump_clock_select = s.opt1[`SOPR_B_CHARGE_PUMP_CLOCK_SELECT];
  assign opts.clock_monitor_active     = s.opt1[`SOPR_B_CME] | s.opt1[`SOPR_B_CLOCK_MONITOR_FORCE];
  assign opts.watchdog_rate_sel        = s.opt1[1:0];
  assign opts.serial_lsb_first         = s.system_options_2[`SOPR_B_SERIAL_LSB_FIRST];
  assign opts.serial_rate_div4         = s.system_options_2[`SOPR_B_SDIV4];
  assign opts.internal_read_visibility = expanded_mode & s.system_options_2[`SOPR_B_IRVBC];
  assign opts.busclk_hold_low          = ~expanded_mode & s.system_options_2[`SOPR_B_IRVBC];

  // level mode reads the synced pin, edge mode a one cycle fall pulse
  assign irq_request = s.opt1[`SOPR_B_IRQ_EDGE_SELECT] ? (s.irq_s3 & ~s.irq_s2) : ~s.irq_s2;
  assign cpu_hold         = s.osc == SOPR_WAIT;
  assign clock_fail_reset = opts.clock_monitor_active & clock_slow_det;
  assign stop_allowed     = ~s.opt1[`SOPR_B_CLOCK_MONITOR_FORCE];

  assign instr_start_strobe_n_o  = s.lir_hi;
  assign instr_start_strobe_n_oe = s.lir_lo | s.lir_hi;
  assign portc_o       = s.pc_o;
  assign portc_oe      = s.pc_oe;
  assign aux_clock_pin = s.aux_pin;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence short_wait_s;
    cpu_hold [*4] ##1 !cpu_hold;
  endsequence

  a_prot_locked: assert property (
    !special_mode && !win_open |=> (s.opt1 & `SOPR_OPT1_PROT) == ($past(s.opt1) & `SOPR_OPT1_PROT))
    else $error("protected option bits changed after window");
  a_short_delay: assert property (
    !cpu_hold && stop_exit && !s.opt1[`SOPR_B_DLY] |=> short_wait_s)
    else $error("short start-up delay not four cycles");
  a_irq_edge: assert property (
    s.opt1[`SOPR_B_IRQ_EDGE_SELECT] && $fell(s.irq_s2) |-> irq_request ##1 !irq_request || $fell(s.irq_s2))
    else $error("falling edge request not a single pulse");
  a_force_sticky: assert property (
    s.opt1[`SOPR_B_CLOCK_MONITOR_FORCE] |=> s.opt1[`SOPR_B_CLOCK_MONITOR_FORCE] && opts.clock_monitor_active)
    else $error("forced clock monitor dropped");
  a_clock_fail: assert property (
    s.opt1[`SOPR_B_CLOCK_MONITOR_FORCE] && clock_slow_det |-> clock_fail_reset && !stop_allowed)
    else $error("slow clock ignored with force set");
  a_protect_only: assert property (
    !special_mode && !win_open |=> (s.eeprom_block_protect & $past(s.eeprom_block_protect)) == $past(s.eeprom_block_protect))
    else $error("protect bit cleared outside window");
  a_od_no_high: assert property (
    s.system_options_2[`SOPR_B_CPOD] ##1 s.system_options_2[`SOPR_B_CPOD] |-> (portc_o & portc_oe) == 8'h00)
    else $error("open drain port drove high");
  a_strobe_seq: assert property (
    instr_begin && expanded_mode && s.system_options_2[`SOPR_B_LIRDRV] |=>
      instr_start_strobe_n_oe && !instr_start_strobe_n_o ##1 instr_start_strobe_n_o)
    else $error("strobe low then high drive missing");
  a_cfg_guard: assert property (
    ee_req.cfg_write && s.eeprom_block_protect[`SOPR_B_PTCFG] && !special_mode |-> ee_denied)
    else $error("config write not blocked");
  a_adc_settle: assert property (
    $rose(s.opt1[`SOPR_B_ANALOG_POWER_UP]) |-> !s.adc_ready [*8])
    else $error("converter ready too early");

endmodule : sopr_top

// ### core/sopr_cfg.svh
// offsets, field positions, reset values and timing counts for the option block
`ifndef SOPR_CFG_SVH
`define SOPR_CFG_SVH

// ----------------------------------------------------------------
// register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define SOPR_IDX_SYSTEM_OPTIONS_2   10'h038
`define SOPR_IDX_OPT1   10'h039
`define SOPR_IDX_EEPROM_BLOCK_PROTECT  10'h03a
`define SOPR_IDX_STAT   10'h03b

// ----------------------------------------------------------------
// reset values and write masks
// ----------------------------------------------------------------
`define SOPR_RST_OPT1   8'h10
`define SOPR_RST_SYSTEM_OPTIONS_2   8'h00
`define SOPR_RST_EEPROM_BLOCK_PROTECT  8'hff
`define SOPR_OPT1_PROT  8'h37
`define SOPR_SYSTEM_OPTIONS_2_WMASK 8'hcf

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define SOPR_B_ANALOG_POWER_UP     7
`define SOPR_B_CHARGE_PUMP_CLOCK_SELECT     6
`define SOPR_B_IRQ_EDGE_SELECT     5
`define SOPR_B_DLY      4
`define SOPR_B_CME      3
`define SOPR_B_CLOCK_MONITOR_FORCE     2
`define SOPR_B_LIRDRV   7
`define SOPR_B_CPOD     6
`define SOPR_B_IRVBC    4
`define SOPR_B_SERIAL_LSB_FIRST     3
`define SOPR_B_SDIV4    2
`define SOPR_B_BULK_ERASE_PROTECT    7
`define SOPR_B_PTCFG    5

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define SOPR_WIN_CYCLES 7'd64
`define SOPR_CLK_NS     100
`define SOPR_ADC_WAIT_NS 100000
`define SOPR_ADC_CYCLES ((`SOPR_ADC_WAIT_NS + `SOPR_CLK_NS - 1) / `SOPR_CLK_NS)
`define SOPR_DLY_LONG   12'd4064
`define SOPR_DLY_SHORT  12'd4
`define SOPR_AUX_SETTLE 5'd16

// ----------------------------------------------------------------
// eeprom block start offsets within the page
// ----------------------------------------------------------------
`define SOPR_BLK0_LO    12'hd80
`define SOPR_BLK1_LO    12'hda0
`define SOPR_BLK2_LO    12'hde0
`define SOPR_BLK3_LO    12'he60
`define SOPR_BLK4_LO    12'hf80

`endif

// ### core/sopr_pkg.sv
// types shared by the system option and protect block
package sopr_pkg;

  // start-up delay sequencer
  typedef enum logic [0:0] {SOPR_RUN, SOPR_WAIT} sopr_osc_t;

  // eeprom access request checked against protection
  typedef struct packed {
    logic        prog;
    logic        row_erase;
    logic        bulk_erase;
    logic        cfg_write;
    logic [11:0] offset;
  } sopr_ee_req_t;

  // decoded option levels towards the rest of the chip
  typedef struct packed {
    logic       analog_power_up;
    logic       charge_pump_clock_select;
    logic       clock_monitor_active;
    logic [1:0] watchdog_rate_sel;
    logic       serial_lsb_first;
    logic       serial_rate_div4;
    logic       internal_read_visibility;
    logic       busclk_hold_low;
  } sopr_opts_t;

  // whole state of the block
  typedef struct packed {
    logic [7:0]  opt1;
    logic [7:0]  system_options_2;
    logic [7:0]  eeprom_block_protect;
    logic [6:0]  win_cnt;
    logic        once_opt1;
    logic        once_irv;
    logic        once_eeprom_block_protect;
    logic        started;
    sopr_osc_t   osc;
    logic [11:0] dly_cnt;
    logic [9:0]  adc_cnt;
    logic        adc_ready;
    logic        irq_s1;
    logic        irq_s2;
    logic        irq_s3;
    logic        lir_lo;
    logic        lir_hi;
    logic [7:0]  pc_o;
    logic [7:0]  pc_oe;
    logic        xt_s1;
    logic        xt_s2;
    logic        xt_s3;
    logic [1:0]  aux_div;
    logic [2:0]  aux_cnt;
    logic        aux_clk;
    logic        aux_pin;
    logic [4:0]  aux_settle;
    logic [31:0] prdata;
  } sopr_state_t;

endpackage : sopr_pkg

// ### tb/tb_top.sv
// self-checking bench for the system option and protect block
`timescale 1ns/1ps
`include "sopr_cfg.svh"
module tb_top;
  import sopr_pkg::*;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic               pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [11:0]        paddr;
  logic [31:0]        pwdata, prdata;
  logic               special_mode, expanded_mode, stop_exit, instr_begin, clock_slow_det;
  logic               irq_n, crystal_input, irq_request, cpu_hold, clock_fail_reset;
  logic               stop_allowed, ee_denied, strobe_o, strobe_oe, aux_pin, aux_prev;
  logic [7:0]         portc_data, portc_dir, portc_o, portc_oe, rd;
  sopr_ee_req_t       ee_req;
  sopr_opts_t         opts;
  int                 miscompares, checks_done, n;
  localparam logic [11:0] A_SYSTEM_OPTIONS_2 = {`SOPR_IDX_SYSTEM_OPTIONS_2, 2'b00};
  localparam logic [11:0] A_OPT1 = {`SOPR_IDX_OPT1, 2'b00};
  localparam logic [11:0] A_BPR  = {`SOPR_IDX_EEPROM_BLOCK_PROTECT, 2'b00};
  localparam logic [11:0] A_STA  = {`SOPR_IDX_STAT, 2'b00};
  logic [11:0] blk_lo [5] = '{12'hd80, 12'hda0, 12'hde0, 12'he60, 12'hf80};
  logic [11:0] blk_hi [5] = '{12'hd9f, 12'hddf, 12'he5f, 12'hf7f, 12'hfff};
  int          divs   [4] = '{1, 4, 6, 8};

  sopr_top i_sopr_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .special_mode(special_mode), .expanded_mode(expanded_mode), .stop_exit(stop_exit),
    .instr_begin(instr_begin), .clock_slow_det(clock_slow_det), .aux_clock_out_en(1'b1),
    .irq_n(irq_n), .crystal_input(crystal_input), .portc_data(portc_data), .portc_dir(portc_dir),
    .ee_req(ee_req), .opts(opts), .irq_request(irq_request), .cpu_hold(cpu_hold),
    .clock_fail_reset(clock_fail_reset), .stop_allowed(stop_allowed), .ee_denied(ee_denied),
    .instr_start_strobe_n_o(strobe_o), .instr_start_strobe_n_oe(strobe_oe), .portc_o(portc_o),
    .portc_oe(portc_oe), .aux_clock_pin(aux_pin));

  // ----------------------------------------------------------------
  // clock, crystal and edge history
  // ----------------------------------------------------------------
  // bus clock, 100 ns period
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  // crystal well below half the bus rate so the sampler sees every edge
  initial begin
    crystal_input = 1'b0;
    forever begin
      repeat (4) @(posedge pclk);
      crystal_input <= ~crystal_input;
    end
  end
  // previous aux pin level for rise detection
  always @(posedge pclk) aux_prev <= aux_pin;

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %0t %s: got %h expected %h", $time, what, got, exp);
    end
  endtask : chk

  // one apb transfer; holds everything until pready is seen high
  task automatic apb(input logic wr, input logic [11:0] a, input logic [7:0] d);
    int k;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 16);
    if (k >= 16) begin
      miscompares++;
      end_of_test();
    end
    rd = prdata[7:0];
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rdc(input logic [11:0] a, input logic [7:0] exp);
    apb(1'b0, a, 8'h00);
    chk(rd, exp, "register read");
  endtask : rdc

  task automatic rst(input logic sp, input logic ex);
    @(posedge pclk);
    special_mode  <= sp;
    expanded_mode <= ex;
    presetn       <= 1'b0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
  endtask : rst

  // length of the current or next hold interval in cycles
  task automatic cnt_hold(output int c);
    int i;
    c = 0;
    for (i = 0; i < 5000; i++) begin
      @(posedge pclk);
      if (cpu_hold === 1'b1) c++;
      else if (c > 0) break;
    end
    if (i >= 5000) begin
      miscompares++;
      end_of_test();
    end
  endtask : cnt_hold

  task automatic pulse_stop;
    @(posedge pclk);
    stop_exit <= 1'b1;
    @(posedge pclk);
    stop_exit <= 1'b0;
  endtask : pulse_stop

  task automatic ee(input logic [3:0] kind, input logic [11:0] off, input logic exp);
    @(posedge pclk);
    ee_req <= sopr_ee_req_t'({kind, off});
    @(posedge pclk);
    chk(ee_denied, exp, "eeprom check");
  endtask : ee

  // instruction start, then strobe {oe,o} in the two cycles after
  task automatic strobe(input logic [1:0] e1, input logic [1:0] e2);
    @(posedge pclk);
    instr_begin <= 1'b1;
    @(posedge pclk);
    instr_begin <= 1'b0;
    @(posedge pclk);
    chk({strobe_oe, strobe_o}, e1, "strobe first");
    @(posedge pclk);
    chk({strobe_oe, strobe_o}, e2, "strobe second");
  endtask : strobe

  task automatic rise(output int k);
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (!(aux_pin === 1'b1 && aux_prev === 1'b0) && k < 300);
    if (!(aux_pin === 1'b1 && aux_prev === 1'b0)) begin
      miscompares++;
      end_of_test();
    end
  endtask : rise

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : end_of_test

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    {presetn, psel, penable, pwrite, special_mode, expanded_mode} = '0;
    {stop_exit, instr_begin, clock_slow_det, paddr, pwdata, portc_data, portc_dir} = '0;
    irq_n = 1'b1;
    ee_req = '0;
    miscompares = 0;
    checks_done = 0;
    // normal single chip, inside the protection window
    rst(1'b0, 1'b0);
    rdc(A_OPT1, 8'h10);
    rdc(A_SYSTEM_OPTIONS_2, 8'h00);
    rdc(A_BPR, 8'hff);
    apb(1'b1, A_OPT1, 8'h36);
    rdc(A_OPT1, 8'h36);
    chk(opts.clock_monitor_active, 1'b1, "monitor forced");
    chk(stop_allowed, 1'b0, "stop allowed");
    chk(opts.watchdog_rate_sel, 2'b10, "watchdog rate");
    apb(1'b1, A_OPT1, 8'hc0);
    rdc(A_OPT1, 8'hf6);
    chk(opts.analog_power_up, 1'b1, "analog power");
    chk(opts.charge_pump_clock_select, 1'b1, "pump clock");
    @(posedge pclk);
    clock_slow_det <= 1'b1;
    @(posedge pclk);
    chk(clock_fail_reset, 1'b1, "clock fail");
    clock_slow_det <= 1'b0;
    apb(1'b1, A_BPR, 8'h00);
    rdc(A_BPR, 8'h00);
    ee(4'b0010, 12'hd80, 1'b0);
    apb(1'b1, A_BPR, 8'h20);
    ee(4'b0001, 12'h000, 1'b1);
    apb(1'b1, A_BPR, 8'h80);
    rdc(A_BPR, 8'ha0);
    ee(4'b0010, 12'hd80, 1'b1);
    ee(4'b0100, 12'hd80, 1'b1);
    ee(4'b1000, 12'hd80, 1'b0);
    apb(1'b1, A_BPR, 8'h00);
    rdc(A_BPR, 8'ha0);
    apb(1'b1, A_SYSTEM_OPTIONS_2, 8'hdf);
    rdc(A_SYSTEM_OPTIONS_2, 8'hdf);
    chk(opts.busclk_hold_low, 1'b1, "bus clock held");
    chk({opts.serial_lsb_first, opts.serial_rate_div4}, 2'b11, "serial options");
    apb(1'b1, A_SYSTEM_OPTIONS_2, 8'h00);
    rdc(A_SYSTEM_OPTIONS_2, 8'h10);
    @(posedge pclk);
    irq_n <= 1'b0;
    n = 0;
    repeat (12) begin
      @(posedge pclk);
      if (irq_request === 1'b1) n++;
    end
    chk(n, 1, "edge requests");
    irq_n <= 1'b1;
    apb(1'b0, 12'h0f0, 8'h00);
    chk({err, rd}, 9'h100, "unmapped access");
    strobe(2'b00, 2'b00);
    $display("test normal window done");
    // normal mode after the window has closed
    rst(1'b0, 1'b0);
    repeat (70) @(posedge pclk);
    apb(1'b1, A_OPT1, 8'h00);
    rdc(A_OPT1, 8'h10);
    apb(1'b1, A_BPR, 8'h00);
    rdc(A_BPR, 8'hff);
    apb(1'b1, A_OPT1, 8'h08);
    rdc(A_OPT1, 8'h18);
    chk(opts.clock_monitor_active, 1'b1, "monitor enable");
    $display("test window closed done");
    // special test mode: unlimited writes, delays, pins
    rst(1'b1, 1'b1);
    rdc(A_SYSTEM_OPTIONS_2, 8'h10);
    chk(opts.internal_read_visibility, 1'b1, "read visibility");
    cnt_hold(n);
    chk(n >= 4060 && n <= 4070, 1'b1, "power on hold");
    apb(1'b1, A_OPT1, 8'h00);
    rdc(A_OPT1, 8'h00);
    chk(opts.clock_monitor_active, 1'b0, "monitor off");
    pulse_stop();
    cnt_hold(n);
    chk(n, 4, "short hold");
    apb(1'b1, A_OPT1, 8'h10);
    rdc(A_OPT1, 8'h10);
    pulse_stop();
    cnt_hold(n);
    chk(n, 4064, "long hold");
    @(posedge pclk);
    irq_n <= 1'b0;
    repeat (4) @(posedge pclk);
    n = 0;
    repeat (8) begin
      @(posedge pclk);
      if (irq_request === 1'b1) n++;
    end
    chk(n, 8, "level request");
    irq_n <= 1'b1;
    apb(1'b1, A_SYSTEM_OPTIONS_2, 8'h80);
    strobe(2'b10, 2'b11);
    apb(1'b1, A_SYSTEM_OPTIONS_2, 8'h40);
    portc_dir  <= 8'hff;
    portc_data <= 8'h0f;
    repeat (3) @(posedge pclk);
    chk({portc_oe, portc_o & portc_oe}, 16'hf000, "open drain");
    apb(1'b1, A_SYSTEM_OPTIONS_2, 8'h00);
    repeat (3) @(posedge pclk);
    chk({portc_oe, portc_o}, 16'hff0f, "push pull");
    for (int c = 0; c < 4; c++) begin
      apb(1'b1, A_SYSTEM_OPTIONS_2, 8'(c));
      // status: mode bits set, settling only after a real rate change
      rdc(A_STA, (c == 0) ? 8'h30 : 8'h38);
      repeat (20) @(posedge pclk);
      rdc(A_STA, 8'h30);
      rise(n);
      rise(n);
      chk(n, 8 * divs[c], "aux period");
    end
    for (int b = 0; b < 5; b++) begin
      apb(1'b1, A_BPR, 8'(1 << b));
      ee(4'b1000, blk_hi[b], 1'b1);
      ee(4'b1000, blk_lo[(b + 1) % 5], 1'b0);
    end
    apb(1'b1, A_BPR, 8'h20);
    ee(4'b0001, 12'h000, 1'b0);
    $display("test special mode done");
    end_of_test();
  end
endmodule : tb_top
